// [verilog/lsrh_pkg.sv]
// lsrh_pkg: offsets, field layout, reset values and carrier types
// for the low-speed threshold and first root hub descriptor registers.
// assumes a byte-addressed register port inside the controller core.
package lsrh_pkg;

  localparam logic [7:0] LSRH_OFS_LS_THRESH = 8'h44;
  localparam logic [7:0] LSRH_OFS_RH_DESC_A = 8'h48;

  localparam int LSRH_LIMIT_W = 12;
  localparam int LSRH_FRAME_W = 14;
  localparam logic [11:0] LSRH_LIMIT_RESET = 12'h628;

  // descriptor fields
  localparam int LSRH_PGOOD_LSB = 24;
  localparam int LSRH_NOPROT_BIT = 12;
  localparam int LSRH_OCMODE_BIT = 11;
  localparam int LSRH_COMPOUND_BIT = 10;
  localparam int LSRH_ALWAYS_PWR_BIT = 9;
  localparam int LSRH_SWMODE_BIT = 8;
  localparam logic [7:0] LSRH_PGOOD_RESET = 8'hFF;
  localparam logic LSRH_NOPROT_RESET = 1'b0;
  localparam logic LSRH_OCMODE_RESET = 1'b1;
  localparam logic LSRH_ALWAYS_PWR_RESET = 1'b0;
  localparam logic LSRH_SWMODE_RESET = 1'b1;
  localparam logic [7:0] LSRH_PORTS_RESET = 8'h02;
  localparam logic [7:0] LSRH_PORTS_MIN = 8'h01;
  localparam logic [7:0] LSRH_PORTS_MAX = 8'h0F;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
    logic [31:0] wdata;
  } lsrh_req_t;

  typedef struct packed {
    logic [7:0] power_good_delay;
    logic no_overcurrent_protect;
    logic overcurrent_report_mode;
    logic ports_always_powered;
    logic power_switch_mode;
  } lsrh_desc_t;

endpackage

// [verilog/lsrh_regs.sv]
// lsrh_regs: low-speed start threshold and first root hub descriptor
// register bank, plus the low-speed start decision.
// assumes frame_time_left and requests come from logic on mclk_i.
`timescale 1ns/10ps

// How it works
// - threshold decides low-speed packet commit
// - start only when time left >= threshold
// - threshold in bits 11:0, rest reserved
// - hardware never alters the threshold itself
// - descriptor loads own defaults at reset
// - descriptor register presents root hub traits
// - port count reported between one and fifteen
// - power switch mode: ganged or per port
// - no-protect bit overrides overcurrent mode
module lsrh_regs #(
  parameter logic [7:0] NUM_PORTS = lsrh_pkg::LSRH_PORTS_RESET
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic resetn_i,
  // register port
  input wire lsrh_pkg::lsrh_req_t req_i,
  output logic ack_o,
  output logic [31:0] rdata_o,
  // low-speed scheduling
  input wire logic ls_sched_i,
  input wire logic [13:0] frame_time_left_i,
  output logic ls_start_o,
  output logic ls_defer_o,
  // root hub characteristics
  output logic [11:0] low_speed_start_limit_o,
  output logic [7:0] downstream_port_count_o,
  output logic ports_ganged_o,
  output logic overcurrent_per_port_o,
  output logic overcurrent_none_o
);

  // clamp of the port count
  function automatic logic [7:0] clamp_ports(input logic [7:0] n);
    if (n < lsrh_pkg::LSRH_PORTS_MIN)
      return lsrh_pkg::LSRH_PORTS_MIN;
    else if (n > lsrh_pkg::LSRH_PORTS_MAX)
      return lsrh_pkg::LSRH_PORTS_MAX;
    else
      return n;
  endfunction

  // one request aimed at one register, read or write
  function automatic logic hits(
    input lsrh_pkg::lsrh_req_t r,
    input logic [7:0] ofs,
    input logic wr
  );
    return r.valid && (r.write == wr) && (r.addr == ofs);
  endfunction

  // descriptor word as software sees it
  function automatic logic [31:0] pack_desc(
    input lsrh_pkg::lsrh_desc_t d,
    input logic [7:0] ports
  );
    logic [31:0] w;
    w = '0;
    w[lsrh_pkg::LSRH_PGOOD_LSB +: 8] = d.power_good_delay;
    w[lsrh_pkg::LSRH_NOPROT_BIT] = d.no_overcurrent_protect;
    w[lsrh_pkg::LSRH_OCMODE_BIT] = d.overcurrent_report_mode;
    // compound device flag always reads zero
    w[lsrh_pkg::LSRH_COMPOUND_BIT] = 1'b0;
    w[lsrh_pkg::LSRH_ALWAYS_PWR_BIT] = d.ports_always_powered;
    w[lsrh_pkg::LSRH_SWMODE_BIT] = d.power_switch_mode;
    w[7:0] = ports;
    return w;
  endfunction

  localparam logic [7:0] PORTS = clamp_ports(NUM_PORTS);

  // register contents
  logic [11:0] limit_q, limit_d;
  lsrh_pkg::lsrh_desc_t desc_q, desc_d;
  // bus answer
  logic ack_q, ack_d;
  logic [31:0] rdata_q, rdata_d;
  // scheduling answer
  logic start_q, start_d;
  logic defer_q, defer_d;
  // derived root hub modes
  logic gang_q, gang_d;
  logic ocpp_q, ocpp_d;
  logic ocnone_q, ocnone_d;
  logic [7:0] ports_q, ports_d;
  // decoded accesses
  logic wr_limit, wr_desc;
  logic rd_limit, rd_desc;

  // register contents: next values
  always_comb
  begin
    wr_limit = hits(req_i, lsrh_pkg::LSRH_OFS_LS_THRESH, 1'b1);
    wr_desc = hits(req_i, lsrh_pkg::LSRH_OFS_RH_DESC_A, 1'b1);
    limit_d = limit_q;
    desc_d = desc_q;
    if (wr_limit)
      limit_d = req_i.wdata[lsrh_pkg::LSRH_LIMIT_W-1:0];
    if (wr_desc)
    begin
      desc_d.power_good_delay =
        req_i.wdata[lsrh_pkg::LSRH_PGOOD_LSB +: 8];
      desc_d.no_overcurrent_protect =
        req_i.wdata[lsrh_pkg::LSRH_NOPROT_BIT];
      desc_d.overcurrent_report_mode =
        req_i.wdata[lsrh_pkg::LSRH_OCMODE_BIT];
      desc_d.ports_always_powered =
        req_i.wdata[lsrh_pkg::LSRH_ALWAYS_PWR_BIT];
      desc_d.power_switch_mode =
        req_i.wdata[lsrh_pkg::LSRH_SWMODE_BIT];
    end
  end

  // register contents: flops
  always_ff @(posedge mclk_i)
  begin
    if (!resetn_i)
    begin
      limit_q <= lsrh_pkg::LSRH_LIMIT_RESET;
      desc_q.power_good_delay <= lsrh_pkg::LSRH_PGOOD_RESET;
      desc_q.no_overcurrent_protect <= lsrh_pkg::LSRH_NOPROT_RESET;
      desc_q.overcurrent_report_mode <= lsrh_pkg::LSRH_OCMODE_RESET;
      desc_q.ports_always_powered <= lsrh_pkg::LSRH_ALWAYS_PWR_RESET;
      desc_q.power_switch_mode <= lsrh_pkg::LSRH_SWMODE_RESET;
    end
    else
    begin
      limit_q <= limit_d;
      desc_q <= desc_d;
    end
  end

  // bus answer: next values
  always_comb
  begin
    rd_limit = hits(req_i, lsrh_pkg::LSRH_OFS_LS_THRESH, 1'b0);
    rd_desc = hits(req_i, lsrh_pkg::LSRH_OFS_RH_DESC_A, 1'b0);
    // every request is answered, unmapped ones too
    ack_d = req_i.valid;
    rdata_d = '0;
    if (rd_limit)
      rdata_d = {20'h00000, limit_q};
    else if (rd_desc)
      rdata_d = pack_desc(desc_q, PORTS);
  end

  // bus answer: flops
  always_ff @(posedge mclk_i)
  begin
    if (!resetn_i)
    begin
      ack_q <= 1'b0;
      rdata_q <= '0;
    end
    else
    begin
      ack_q <= ack_d;
      rdata_q <= rdata_d;
    end
  end

  // scheduling answer: next values
  always_comb
  begin
    // compare per schedule attempt
    // a same-edge threshold write is seen only by later attempts
    start_d = ls_sched_i && ({2'b00, limit_q} <= frame_time_left_i);
    defer_d = ls_sched_i && ({2'b00, limit_q} > frame_time_left_i);
  end

  // scheduling answer: flops
  always_ff @(posedge mclk_i)
  begin
    if (!resetn_i)
    begin
      start_q <= 1'b0;
      defer_q <= 1'b0;
    end
    else
    begin
      start_q <= start_d;
      defer_q <= defer_d;
    end
  end

  // derived modes: next values
  always_comb
  begin
    gang_d = desc_q.ports_always_powered || !desc_q.power_switch_mode;
    ocnone_d = desc_q.no_overcurrent_protect;
    ocpp_d = !desc_q.no_overcurrent_protect &&
             desc_q.overcurrent_report_mode;
    ports_d = PORTS;
  end

  // derived modes: flops, one cycle behind the descriptor
  always_ff @(posedge mclk_i)
  begin
    if (!resetn_i)
    begin
      gang_q <= 1'b0;
      ocpp_q <= 1'b0;
      ocnone_q <= 1'b0;
      ports_q <= PORTS;
    end
    else
    begin
      gang_q <= gang_d;
      ocpp_q <= ocpp_d;
      ocnone_q <= ocnone_d;
      ports_q <= ports_d;
    end
  end

  // every output straight from a flop
  assign ack_o = ack_q;
  assign rdata_o = rdata_q;
  assign ls_start_o = start_q;
  assign ls_defer_o = defer_q;
  assign low_speed_start_limit_o = limit_q;
  assign downstream_port_count_o = ports_q;
  assign ports_ganged_o = gang_q;
  assign overcurrent_per_port_o = ocpp_q;
  assign overcurrent_none_o = ocnone_q;

endmodule // lsrh_regs

// [dv/lsrh_regs_checker.sv]
// lsrh_regs_checker: port assertions for the threshold/descriptor bank
// assumes one clock, synchronous active-low reset
`timescale 1ns/10ps
module lsrh_regs_checker (
  // clock, reset, register port
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire lsrh_pkg::lsrh_req_t req_i,
  input wire logic ack_o,
  input wire logic [31:0] rdata_o,
  // scheduling and modes
  input wire logic ls_sched_i,
  input wire logic [13:0] frame_time_left_i,
  input wire logic ls_start_o,
  input wire logic ls_defer_o,
  input wire logic [11:0] low_speed_start_limit_o,
  input wire logic [7:0] downstream_port_count_o,
  input wire logic overcurrent_per_port_o,
  input wire logic overcurrent_none_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  sequence s_rd(logic [7:0] a);
    req_i.valid && !req_i.write && req_i.addr == a;
  endsequence
  sequence s_go;
    ls_sched_i && frame_time_left_i >= {2'h0, low_speed_start_limit_o};
  endsequence
  sequence s_stop;
    ls_sched_i && frame_time_left_i < {2'h0, low_speed_start_limit_o};
  endsequence
  property p_ack;
    req_i.valid |=> ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("ack missing");
  property p_start;
    s_go |=> ls_start_o && !ls_defer_o;
  endproperty
  a_start: assert property (p_start) else $error("start wrong");
  property p_defer;
    s_stop |=> ls_defer_o && !ls_start_o;
  endproperty
  a_defer: assert property (p_defer) else $error("defer wrong");
  property p_idle;
    !ls_sched_i |=> !ls_start_o && !ls_defer_o;
  endproperty
  a_idle: assert property (p_idle) else $error("spurious start");
  property p_hold;
    !(req_i.valid && req_i.write &&
      req_i.addr == lsrh_pkg::LSRH_OFS_LS_THRESH)
      |=> $stable(low_speed_start_limit_o);
  endproperty
  a_hold: assert property (p_hold) else $error("threshold moved");
  property p_ndp;
    downstream_port_count_o inside {[8'h01:8'h0F]};
  endproperty
  a_ndp: assert property (p_ndp) else $error("port count range");
  property p_oc;
    overcurrent_none_o |-> !overcurrent_per_port_o;
  endproperty
  a_oc: assert property (p_oc) else $error("oc mode not ignored");
  property p_rsv;
    s_rd(lsrh_pkg::LSRH_OFS_LS_THRESH) |=> rdata_o[31:12] == 20'h0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits set");
  property p_desc;
    s_rd(lsrh_pkg::LSRH_OFS_RH_DESC_A) |=> !rdata_o[10] &&
      rdata_o[23:13] == 11'h0 &&
      rdata_o[7:0] == downstream_port_count_o;
  endproperty
  a_desc: assert property (p_desc) else $error("descriptor bits");
endmodule // lsrh_regs_checker

bind lsrh_regs lsrh_regs_checker u_chk (
  .mclk_i(mclk_i),
  .resetn_i(resetn_i),
  .req_i(req_i),
  .ack_o(ack_o),
  .rdata_o(rdata_o),
  .ls_sched_i(ls_sched_i),
  .frame_time_left_i(frame_time_left_i),
  .ls_start_o(ls_start_o),
  .ls_defer_o(ls_defer_o),
  .low_speed_start_limit_o(low_speed_start_limit_o),
  .downstream_port_count_o(downstream_port_count_o),
  .overcurrent_per_port_o(overcurrent_per_port_o),
  .overcurrent_none_o(overcurrent_none_o)
);

// [dv/lsrh_regs_tb_top.sv]
// lsrh_regs_tb_top: register and low-speed start decision tests
// assumes the checker is bound by its own file
`timescale 1ns/10ps
module usb_host_ls_threshold_roothub_desc_tb_top;
  typedef struct packed {logic [13:0] ftl; logic go;} lsrh_row_t;
  logic mclk_i = 1'b0;
  logic resetn_i = 1'b0;
  lsrh_pkg::lsrh_req_t req_i = '0;
  logic ls_sched_i = 1'b0;
  logic [13:0] frame_time_left_i = 14'h0;
  logic ack_o, ls_start_o, ls_defer_o, ports_ganged_o;
  logic overcurrent_per_port_o, overcurrent_none_o;
  logic [31:0] rdata_o, rd;
  logic [11:0] low_speed_start_limit_o;
  logic [7:0] downstream_port_count_o;
  int miscompares = 0;
  int cmp_count = 0;
  int cyc = 0;
  lsrh_row_t rows [5] = '{'{14'h627, 1'b0}, '{14'h628, 1'b1},
    '{14'h629, 1'b1}, '{14'h0, 1'b0}, '{14'h3FFF, 1'b1}};
  always #5 mclk_i = ~mclk_i;
  lsrh_regs u_dut (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .req_i(req_i),
    .ack_o(ack_o),
    .rdata_o(rdata_o),
    .ls_sched_i(ls_sched_i),
    .frame_time_left_i(frame_time_left_i),
    .ls_start_o(ls_start_o),
    .ls_defer_o(ls_defer_o),
    .low_speed_start_limit_o(low_speed_start_limit_o),
    .downstream_port_count_o(downstream_port_count_o),
    .ports_ganged_o(ports_ganged_o),
    .overcurrent_per_port_o(overcurrent_per_port_o),
    .overcurrent_none_o(overcurrent_none_o)
  );
  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    cmp_count++;
    if (s !== e)
    begin
      miscompares++;
      $display("wrong value %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge mclk_i);
    req_i <= '{1'b1, w, a, d};
    @(posedge mclk_i);
    req_i.valid <= 1'b0;
    @(negedge mclk_i);
    chk("ack", 32'h1, {31'h0, ack_o});
    rd = rdata_o;
    if (w) chk("write rdata", 32'h0, rd);
  endtask
  task automatic sched(logic [13:0] f, logic go);
    @(posedge mclk_i);
    ls_sched_i <= 1'b1;
    frame_time_left_i <= f;
    @(posedge mclk_i);
    ls_sched_i <= 1'b0;
    @(negedge mclk_i);
    chk("start", {31'h0, go}, {31'h0, ls_start_o});
    chk("defer", {31'h0, !go}, {31'h0, ls_defer_o});
  endtask
  task automatic modes(logic [31:0] e);
    @(negedge mclk_i);
    chk("modes", e, {29'h0, ports_ganged_o, overcurrent_per_port_o,
      overcurrent_none_o});
  endtask
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge mclk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 1000)
    begin
      miscompares++;
      tally_and_finish;
    end
  end
  initial
  begin
    repeat (16) @(posedge mclk_i);
    resetn_i <= 1'b1;
    foreach (rows[i]) sched(rows[i].ftl, rows[i].go);
    bus(1'b0, 8'h44, 32'h0);
    chk("limit", 32'h628, rd);
    chk("limit out", 32'h628, {20'h0, low_speed_start_limit_o});
    bus(1'b0, 8'h48, 32'h0);
    chk("desc", 32'hFF000902, rd);
    chk("ports", 32'h2, {24'h0, downstream_port_count_o});
    modes(32'h2);
    bus(1'b1, 8'h44, 32'h00000123);
    bus(1'b0, 8'h44, 32'h0);
    chk("limit", 32'h123, rd);
    chk("limit out", 32'h123, {20'h0, low_speed_start_limit_o});
    sched(14'h123, 1'b1);
    sched(14'h122, 1'b0);
    bus(1'b1, 8'h48, 32'h05001400);
    bus(1'b0, 8'h48, 32'h0);
    chk("desc", 32'h05001002, rd);
    modes(32'h5);
    bus(1'b1, 8'h48, 32'h01000300);
    modes(32'h4);
    bus(1'b0, 8'h50, 32'h0);
    chk("unmapped", 32'h0, rd);
    bus(1'b1, 8'h44, 32'h00000200);
    @(posedge mclk_i);
    resetn_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    resetn_i <= 1'b1;
    bus(1'b0, 8'h44, 32'h0);
    chk("limit reset", 32'h628, rd);
    bus(1'b0, 8'h48, 32'h0);
    chk("desc reset", 32'hFF000902, rd);
    modes(32'h2);
    tally_and_finish;
  end
endmodule // usb_host_ls_threshold_roothub_desc_tb_top
